// >>> core/input_port_params.svh
// Register map, reset values and timing figures of the input port
// Notes on behaviour
// - Four general input bits, each sampled from its own pin.
// - Fourth pin level also drives the timer clock input.
// - Per-bit pull-up chosen at build time, not by software.
// - Every bit can interrupt, each with its own software enable.
// - Enabled bit falling high to low sets the shared flag.
// - Masked bit changes never set the shared flag.
// - One shared flag at F04H bit 0; reads one after interrupt; writes ignored.
// - Enables live in read/write register F14H, one bit per input.
// - Reset clears all enables, so every input starts masked.
// - Reset clears the shared flag.
// - F40H reads live pin levels; writes there have no effect.
// - Re-enabling a bit while its pin is low may set the flag again.
`ifndef INPUT_PORT_PARAMS_SVH
`define INPUT_PORT_PARAMS_SVH
`define IP_ADDR_W 12
`define IP_OFS_FLAG 12'hf04
`define IP_OFS_ENABLE 12'hf14
`define IP_OFS_IRQ_STATUS 12'hf20
`define IP_OFS_IRQ_MASK 12'hf24
`define IP_OFS_LEVEL 12'hf40
`define IP_FLAG_BIT 0
`define IP_ENABLE_RESET 4'h0
`define IP_FLAG_RESET 1'b0
`define IP_IRQ_STATUS_RESET 4'h0
`define IP_IRQ_MASK_RESET 4'h0
`define IP_PULLUP_DEFAULT 4'hf
`define IP_SETTLE_US 500
`define IP_CLK_KHZ 40000
`define IP_SETTLE_CYCLES ((`IP_SETTLE_US * `IP_CLK_KHZ) / 1000)
`endif

// >>> core/input_port_pkg.sv
// Types shared by the input port modules
package input_port_pkg;
  typedef enum logic [2:0] {
    REG_NONE = 3'b000,
    REG_FLAG = 3'b001,
    REG_ENABLE = 3'b010,
    REG_LEVEL = 3'b011,
    REG_IRQ_STATUS = 3'b100,
    REG_IRQ_MASK = 3'b101
  } reg_sel_e;
endpackage : input_port_pkg

// >>> core/pin_sample_if.sv
// Synchronised pin levels passed from the sampler to the port core
`timescale 1ns/1ps
interface pin_sample_if #(parameter int N_PINS = 4);
  logic [N_PINS-1:0] level;
  modport sampler (output level);
  modport core (input level);
endinterface : pin_sample_if

// >>> core/pin_sampler.sv
// Two-stage synchroniser for the input pins
`timescale 1ns/1ps
module pin_sampler #(
  parameter int N_PINS = 4
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Pads
  input wire logic [N_PINS-1:0] pins_i,
  // Synchronised levels
  pin_sample_if.sampler smp
);
  logic [N_PINS-1:0] meta_q;
  logic [N_PINS-1:0] sync_q;

  // Reset to high: an undriven pulled-up pin must not fake a falling edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= {N_PINS{1'b1}};
      sync_q <= {N_PINS{1'b1}};
    end else if (ce_i) begin
      meta_q <= pins_i;
      sync_q <= meta_q;
    end
  end

  assign smp.level = sync_q;
endmodule : pin_sampler

// >>> core/input_port.sv
// Four-bit input port with falling-edge interrupt and Wishbone registers
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "input_port_params.svh"
module input_port
  import input_port_pkg::*;
#(
  parameter int N_PINS = 4,
  parameter logic [3:0] PULLUP_MASK = `IP_PULLUP_DEFAULT,
  parameter int SETTLE_CYCLES = `IP_SETTLE_CYCLES
) (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic [`IP_ADDR_W-1:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Pads
  input wire logic [3:0] pins_i,
  output logic [3:0] pullup_en_o,
  // Timer clock and interrupt
  output logic timer_clk_o,
  output logic irq_o
);
  if (N_PINS != 4) begin : g_bad_width
    $error("input_port serves exactly four pins");
  end
  if (SETTLE_CYCLES < 1) begin : g_bad_settle
    $error("SETTLE_CYCLES must be at least one");
  end
  if (SETTLE_CYCLES > 65535) begin : g_big_settle
    $error("SETTLE_CYCLES must fit the 16-bit settle counter");
  end

  function automatic reg_sel_e decode(input logic [`IP_ADDR_W-1:0] a);
    reg_sel_e s;
    s = REG_NONE;
    if (a == `IP_OFS_FLAG) s = REG_FLAG;
    else if (a == `IP_OFS_ENABLE) s = REG_ENABLE;
    else if (a == `IP_OFS_LEVEL) s = REG_LEVEL;
    else if (a == `IP_OFS_IRQ_STATUS) s = REG_IRQ_STATUS;
    else if (a == `IP_OFS_IRQ_MASK) s = REG_IRQ_MASK;
    return s;
  endfunction : decode

  pin_sample_if #(.N_PINS(4)) smp ();

  pin_sampler #(.N_PINS(4)) u_sampler (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .pins_i(pins_i),
    .smp(smp)
  );

  logic [3:0] enable_q;
  logic flag_q;
  logic flag_d;
  logic [3:0] irq_status_q;
  logic [3:0] irq_mask_q;
  logic [3:0] armed_q;
  logic [31:0] dat_q;
  logic ack_q;
  wire logic [3:0] settle_ok;

  wire logic req = cyc_i & stb_i & ~ack_q;
  wire reg_sel_e sel = decode(adr_i);
  wire logic wr_lo = req & we_i & sel_i[0];
  wire logic rd = req & ~we_i;
  // armed when pin low and enabled
  wire logic [3:0] armed = ~smp.level & enable_q;
  // falling edge of enabled pin; also re-enable while low
  wire logic [3:0] event_bits = armed & ~armed_q;
  wire logic any_event = |event_bits;
  // read clears the flag at the acknowledging edge
  wire logic flag_rd = rd & (sel == REG_FLAG);
  wire logic [3:0] w1c = (wr_lo & (sel == REG_IRQ_STATUS)) ? dat_i[3:0] : 4'h0;

  // Set wins over the read-clear so no edge is lost
  assign flag_d = any_event | (flag_q & ~flag_rd);

  // reset masks all inputs and clears the flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enable_q <= `IP_ENABLE_RESET;
      flag_q <= `IP_FLAG_RESET;
      irq_status_q <= `IP_IRQ_STATUS_RESET;
      irq_mask_q <= `IP_IRQ_MASK_RESET;
      armed_q <= 4'h0;
    end else if (ce_i) begin
      // enable register written from the low byte
      if (wr_lo && sel == REG_ENABLE) enable_q <= dat_i[3:0];
      if (wr_lo && sel == REG_IRQ_MASK) irq_mask_q <= dat_i[3:0];
      // flag only set by events, writes ignored
      flag_q <= flag_d;
      irq_status_q <= event_bits | (irq_status_q & ~w1c);
      armed_q <= armed;
    end
  end

  // Per-pin settle indicator, high once the pin has stayed high long enough
  for (genvar i = 0; i < 4; i++) begin : g_settle
    logic [15:0] cnt_q;
    logic ok_q;
    // counts cycles since the pin went high, up to SETTLE_CYCLES, to set the settle indicator
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        cnt_q <= 16'h0000;
        ok_q <= 1'b0;
      end else if (ce_i) begin
        if (!smp.level[i]) begin
          cnt_q <= 16'h0000;
          ok_q <= 1'b0;
        end else if (cnt_q < 16'(SETTLE_CYCLES)) begin
          cnt_q <= cnt_q + 16'h0001;
        end else begin
          ok_q <= 1'b1;
        end
      end
    end
    // One driver per bit keeps the indicator vector single-sourced
    assign settle_ok[i] = ok_q;
  end

  // Bus answer one cycle after the request; unmapped reads give zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_q <= req;
      if (rd) begin
        unique case (sel)
          REG_FLAG: dat_q <= {31'h0000_0000, flag_q};
          REG_ENABLE: dat_q <= {28'h000_0000, enable_q};
          REG_LEVEL: dat_q <= {24'h00_0000, settle_ok, smp.level};
          REG_IRQ_STATUS: dat_q <= {28'h000_0000, irq_status_q};
          REG_IRQ_MASK: dat_q <= {28'h000_0000, irq_mask_q};
          REG_NONE: dat_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign ack_o = ack_q;
  assign dat_o = dat_q;
  assign irq_o = |(irq_status_q & irq_mask_q);
  // pin three feeds the timer clock
  assign timer_clk_o = smp.level[3];
  assign pullup_en_o = PULLUP_MASK;
endmodule : input_port

// >>> tb/input_port_sva.sv
// Port-level assertions for the input port
`timescale 1ns/1ps
module input_port_sva #(
  parameter logic [3:0] PULLUP_MASK = 4'hf
) (
  // Clock and bus
  input wire logic clk_i, rst_i, ce_i, cyc_i, stb_i, we_i, ack_o,
  input wire logic [3:0] sel_i,
  input wire logic [11:0] adr_i,
  input wire logic [31:0] dat_i, dat_o,
  // Pads and outputs
  input wire logic [3:0] pins_i, pullup_en_o,
  input wire logic timer_clk_o, irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire tk = cyc_i && stb_i && ce_i && !ack_o;
  wire ra = ack_o && !we_i;
  bus_ack_a: assert property (tk |=> ack_o) else $error("no ack");
  ack_pulse_a: assert property (ack_o && ce_i |=> !ack_o) else $error("long ack");
  pull_fix_a: assert property (pullup_en_o == PULLUP_MASK) else $error("pull-up");
  timer_clk_a: assert property ($past(ce_i) && $past(ce_i, 2) && !$past(rst_i) &&
    !$past(rst_i, 2) |-> timer_clk_o == $past(pins_i[3], 2)) else $error("timer clock");
  rst_clear_a: assert property (disable iff (1'b0) rst_i |=> !ack_o && !irq_o)
    else $error("reset state");
  irq_mask_a: assert property (tk && we_i && sel_i[0] && adr_i == 12'hf24 &&
    dat_i[3:0] == 4'h0 |=> !irq_o) else $error("masked irq");
  flag_rd_a: assert property (ra && adr_i == 12'hf04 |-> dat_o[31:1] == 31'h0)
    else $error("flag bits");
  en_rd_a: assert property (ra && adr_i == 12'hf14 |-> dat_o[31:4] == 28'h0)
    else $error("enable bits");
  lvl_rd_a: assert property (ra && adr_i == 12'hf40 && !$past(rst_i, 2) &&
    !$past(rst_i, 3) && $past(pins_i, 3) == pins_i && $past(pins_i, 2) == pins_i &&
    $past(pins_i) == pins_i |-> dat_o[3:0] == pins_i) else $error("pin level");
  cover property (ra && adr_i == 12'hf04 && dat_o[0]);
  cover property ($rose(irq_o));
  cover property (tk && we_i && adr_i == 12'hf14);
endmodule : input_port_sva
bind input_port input_port_sva #(.PULLUP_MASK(PULLUP_MASK)) i_sva (.clk_i, .rst_i, .ce_i,
  .cyc_i, .stb_i, .we_i, .ack_o, .sel_i, .adr_i, .dat_i, .dat_o, .pins_i, .pullup_en_o,
  .timer_clk_o, .irq_o);

// >>> tb/key_bank.sv
// Switch bank on the pins: pressed keys pull low
`timescale 1ns/1ps
module key_bank (
  input wire logic clk_i,
  input wire logic [3:0] press_i,
  input wire logic [3:0] pullup_i,
  output logic [3:0] pins_o
);
  initial pins_o = 4'hf;
  // Release rises at the next edge, like a press; without a pull-up the pin stays low
  always @(posedge clk_i) pins_o <= ~press_i & (pins_o | pullup_i);
endmodule : key_bank

// >>> tb/tb.sv
// Self-checking bench for the input port
`timescale 1ns/1ps
module tb;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack_o, irq_o, timer_clk_o;
  logic [11:0] adr = 12'h0;
  logic [31:0] dat = 32'h0, dat_o, q;
  logic [3:0] press = 4'h0, pins, pull;
  logic ce = 1'b1;
  logic [3:0] be = 4'hf;
  int bad_count = 0, n_checks = 0;
  always #12.5 clk_i = ~clk_i;
  input_port #(.SETTLE_CYCLES(8)) i_dut (.clk_i, .rst_i, .ce_i(ce), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .sel_i(be), .adr_i(adr), .dat_i(dat), .dat_o, .ack_o,
    .pins_i(pins), .pullup_en_o(pull), .timer_clk_o, .irq_o);
  key_bank i_keys (.clk_i, .press_i(press), .pullup_i(pull), .pins_o(pins));
  task automatic chk(input string nm, input logic [3:0] s, input logic [3:0] e);
    n_checks++;
    if (s !== e) begin
      $display("unexpected %s: expected %h seen %h", nm, e, s);
      bad_count++;
    end
  endtask : chk
  // Holds the request until ack is sampled; the bench timeout ends a hang
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    cyc <= 0; stb <= 0;
    @(posedge clk_i);
  endtask : wb
  task automatic rd(input logic [11:0] a, input logic [3:0] e);
    wb(1'b0, a, 32'h0);
    chk("read", q[3:0], e);
  endtask : rd
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report
  initial begin
    repeat (4000) @(posedge clk_i);
    bad_count++;
    final_report();
  end
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    rd(12'hf14, 4'h0);
    rd(12'hf04, 4'h0);
    press <= 4'h5;
    repeat (8) @(posedge clk_i);
    rd(12'hf40, 4'ha);
    chk("settle", q[7:4], 4'ha);
    chk("timer", {3'h0, timer_clk_o}, 4'h1);
    wb(1'b1, 12'hf40, 32'h0);
    rd(12'hf40, 4'ha);
    rd(12'hf04, 4'h0);
    wb(1'b1, 12'hf14, 32'ha);
    rd(12'hf14, 4'ha);
    be <= 4'h0;
    wb(1'b1, 12'hf14, 32'h0);
    be <= 4'hf;
    rd(12'hf14, 4'ha);
    wb(1'b1, 12'hf04, 32'h1);
    rd(12'hf04, 4'h0);
    press <= 4'h0;
    wb(1'b1, 12'hf14, 32'h0);
    wb(1'b1, 12'hf24, 32'hf);
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, 12'hf14, 32'h1 << i);
      press <= 4'h1 << i;
      repeat (6) @(posedge clk_i);
      rd(12'hf04, 4'h1);
      rd(12'hf04, 4'h0);
      chk("irq", {3'h0, irq_o}, 4'h1);
      wb(1'b1, 12'hf20, 32'hf);
      chk("irq", {3'h0, irq_o}, 4'h0);
      wb(1'b1, 12'hf14, 32'h0);
      wb(1'b1, 12'hf14, 32'h1 << i);
      repeat (4) @(posedge clk_i);
      rd(12'hf04, 4'h1);
      press <= 4'h0;
      repeat (8) @(posedge clk_i);
    end
    wb(1'b1, 12'hf20, 32'hf);
    wb(1'b1, 12'hf14, 32'h1);
    ce <= 1'b0;
    press <= 4'h9;
    repeat (6) @(posedge clk_i);
    // Enable low freezes the sampler, so the fall is not seen yet
    chk("frozen irq", {3'h0, irq_o}, 4'h0);
    ce <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk("irq", {3'h0, irq_o}, 4'h1);
    chk("timer", {3'h0, timer_clk_o}, 4'h0);
    wb(1'b1, 12'hf24, 32'h0);
    rd(12'hf08, 4'h0);
    wb(1'b1, 12'hf14, 32'hf);
    rst_i <= 1;
    repeat (8) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    rd(12'hf14, 4'h0);
    rd(12'hf04, 4'h0);
    rd(12'hf40, 4'h6);
    final_report();
  end
endmodule : tb
